// ### bench/tlfr_core_test.sv
// self-checking bench of the temperature limit block
`timescale 1ns/10ps
`default_nettype none

module tlfr_core_test;
  import tlfr_pkg::*;
  localparam logic [15:0] T_OK  = 16'h0014;
  localparam logic [15:0] T_LOW = 16'h0002;
  logic              clk = 1'b0;
  logic              link_clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              ctrl_pin = 1'b0;
  logic              other_fault = 1'b0;
  logic [15:0]       temp_linear = T_OK;
  logic              link_req, link_busy, link_done, out_enable;
  logic              ot_warning, ut_warning, ut_fault;
  logic [15:0]       link_rdata;
  tlfr_req_type      link_bus;
  logic [16:0]       expq[$];
  logic [15:0]       shadow[int];
  logic [31:0]       seed = 32'h04D6;
  int                failures = 0;
  int                check_count = 0;
  int                r;
  logic              busy_seen = 1'b0;

  always #50 clk = ~clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  tlfr_core dut (.clk(clk), .arst_n(arst_n), .link_clk(link_clk),
    .link_req(link_req), .link_bus(link_bus), .link_busy(link_busy),
    .link_done(link_done), .link_rdata(link_rdata),
    .temp_linear(temp_linear), .ctrl_pin(ctrl_pin),
    .other_fault(other_fault), .out_enable(out_enable),
    .ot_warning(ot_warning), .ut_warning(ut_warning),
    .ut_fault(ut_fault));
  tlfr_host_model host (.link_clk(link_clk), .link_busy(link_busy),
    .link_done(link_done), .link_req(link_req), .link_bus(link_bus));

  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic init_shadow();
    shadow[TLFR_CODE_OPER]      = {8'h00, TLFR_RST_OPER};
    shadow[TLFR_CODE_OT_WARN]   = TLFR_RST_OT_WARN;
    shadow[TLFR_CODE_UT_WARN]   = TLFR_RST_UT_WARN;
    shadow[TLFR_CODE_UT_FAULT]  = TLFR_RST_UT_FAULT;
    shadow[TLFR_CODE_UT_ACTION] = {8'h00, TLFR_RST_UT_ACTION};
    shadow[TLFR_CODE_TIME_UNIT] = {8'h00, TLFR_RST_TIME_UNIT};
  endtask : init_shadow

  // note the expected answer, then let the host run the access
  task automatic acc(input logic w, input logic [7:0] c,
                     input logic [15:0] d, input logic [16:0] e);
    bit ok;
    expq.push_back(e);
    host.access('{write: w, code: c, wdata: d}, int'(rnd() % 3), ok);
    if (!ok) begin
      failures++;
      finish_test();
    end
  endtask : acc

  // a write answers with the old value; codes with no shadow entry are not compared
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    acc(1'b1, c, d, shadow.exists(c) ? {1'b1, shadow[c]} : 17'h0);
    if (shadow.exists(c)) begin
      shadow[c] = (c inside {8'h51, 8'h52, 8'h53}) ? d : {8'h00, d[7:0]};
    end
  endtask : wr

  task automatic rd(input logic [7:0] c);
    acc(1'b0, c, 16'h0000, {1'b1, shadow.exists(c) ? shadow[c] : 16'h0});
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic wait_oe(input logic v, input int n);
    repeat (n) begin
      @(negedge clk);
      if (out_enable === v) break;
    end
    chk(16'(out_enable), 16'(v));
    if (out_enable !== v) finish_test();
  endtask : wait_oe

  task automatic hold_oe(input logic v, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (out_enable !== v) bad = 1'b1;
    end
    chk(16'(bad), 16'h0000);
  endtask : hold_oe

  // under-temperature for n cycles, output level checked early on
  task automatic trip(input int n, input logic v);
    @(negedge clk);
    temp_linear = T_LOW;
    cyc(2);
    chk(16'(out_enable), 16'(v));
    cyc(n - 2);
    temp_linear = T_OK;
  endtask : trip

  task automatic clr();
    wr(TLFR_CODE_CLR_FAULTS, 16'h0000);
    wait_oe(1'b1, 20);
  endtask : clr

  // answers are compared in arrival order
  always @(posedge link_clk) begin
    if (link_busy === 1'b1) busy_seen = 1'b1;
    if (link_done === 1'b1 && expq.size() > 0) begin
      chk(16'({busy_seen, link_busy}), 16'h0002);
      busy_seen = 1'b0;
      if (expq[0][16]) chk(link_rdata, expq[0][15:0]);
      void'(expq.pop_front());
    end
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    init_shadow();
    cyc(12);
    arst_n = 1'b1;
    ctrl_pin = 1'b1;
    foreach (shadow[c]) rd(8'(c));
    rd(TLFR_CODE_STATUS);
    rd(8'h60);
    for (r = 0; r < 9; r++) begin
      wr(8'(8'h51 + r % 3), 16'(rnd()));
      rd(8'(8'h51 + r % 3));
    end
    wr(TLFR_CODE_OT_WARN, 16'h0028);
    wr(TLFR_CODE_UT_WARN, 16'h000A);
    wr(TLFR_CODE_UT_FAULT, 16'h0005);
    wr(TLFR_CODE_STATUS, 16'hFFFF);
    wait_oe(1'b1, 10);
    @(negedge clk);
    temp_linear = T_LOW;
    hold_oe(1'b1, 40);
    chk({13'h0, ot_warning, ut_warning, ut_fault}, 16'h0003);
    temp_linear = 16'h0032;
    cyc(3);
    chk(16'(ot_warning), 16'h0001);
    temp_linear = T_OK;
    wr(TLFR_CODE_UT_ACTION, 16'h00C0);
    for (r = 0; r < 4; r++) begin
      trip(10, 1'b0);
      hold_oe(1'b0, 30);
      case (r)
        0: wr(TLFR_CODE_CLR_FAULTS, 16'h0000);
        1: wr(TLFR_CODE_STATUS, 16'h0010);
        2: begin
          @(negedge clk);
          ctrl_pin = 1'b0;
          cyc(5);
          ctrl_pin = 1'b1;
        end
        default: begin
          wr(TLFR_CODE_OPER, 16'h0000);
          wr(TLFR_CODE_OPER, 16'h0080);
        end
      endcase
      wait_oe(1'b1, 20);
    end
    for (r = 0; r < 7; r++) begin
      wr(TLFR_CODE_UT_ACTION, {8'h00, 2'b10, 3'(r), 3'b000});
      if (r > 0) begin
        trip(10 * r - 4, 1'b0);
        wait_oe(1'b1, 14);
      end
      trip(10 * r + 6, 1'b0);
      hold_oe(1'b0, 40);
      clr();
    end
    wr(TLFR_CODE_UT_ACTION, 16'h00B8);
    trip(150, 1'b0);
    wait_oe(1'b1, 14);
    @(negedge clk);
    temp_linear = T_LOW;
    other_fault = 1'b1;
    cyc(30);
    other_fault = 1'b0;
    temp_linear = T_OK;
    hold_oe(1'b0, 40);
    clr();
    for (r = 0; r < 5; r++) begin
      wr(TLFR_CODE_TIME_UNIT, 16'(r == 4));
      wr(TLFR_CODE_UT_ACTION, {8'h00, 2'b01, 3'(r == 4), 3'(r % 4)});
      @(negedge clk);
      temp_linear = T_LOW;
      hold_oe(1'b1, (r == 4 ? 20 : 10 << r) - 3);
      wait_oe(1'b0, 8);
      temp_linear = T_OK;
      hold_oe(1'b0, 15);
      if (r == 4) wait_oe(1'b1, 10);
      clr();
    end
    wr(TLFR_CODE_UT_ACTION, 16'h00C0);
    trip(10, 1'b0);
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    init_shadow();
    wait_oe(1'b1, 10);
    rd(TLFR_CODE_UT_ACTION);
    rd(TLFR_CODE_UT_FAULT);
    repeat (4) @(posedge link_clk);
    chk(16'(expq.size()), 16'h0000);
    finish_test();
  end
endmodule : tlfr_core_test
`default_nettype wire

// ### bench/tlfr_host_model.sv
// host model issuing register requests on the link clock
`timescale 1ns/10ps
`default_nettype none

module tlfr_host_model (
  input  wire logic              link_clk,
  input  wire logic              link_busy,
  input  wire logic              link_done,
  output logic                   link_req,
  output tlfr_pkg::tlfr_req_type link_bus
);
  import tlfr_pkg::*;

  initial begin
    link_req = 1'b0;
    link_bus = '0;
  end

  // idle gap, request held until taken, then wait for the answer
  task automatic access(input tlfr_req_type r, input int gap,
                        output bit ok);
    int n;
    repeat (gap + 1) @(posedge link_clk);
    link_req <= 1'b1;
    link_bus <= r;
    n = 0;
    do begin
      @(posedge link_clk);
      n++;
    end while (link_busy !== 1'b0 && n < 20);
    // released lines stop showing the request
    link_req <= 1'b0;
    link_bus <= ~r;
    n = 0;
    do begin
      @(posedge link_clk);
      n++;
    end while (link_done !== 1'b1 && n < 200);
    ok = (link_done === 1'b1);
  endtask : access
endmodule : tlfr_host_model
`default_nettype wire

// ### verilog/tlfr_core.sv
// temperature limits and under-temperature fault response
`timescale 1ns/10ps
`default_nettype none

module tlfr_core (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   link_clk,
  input  wire logic                   link_req,
  input  wire tlfr_pkg::tlfr_req_type link_bus,
  output logic                        link_busy,
  output logic                        link_done,
  output logic [15:0]                 link_rdata,
  input  wire logic [15:0]            temp_linear,
  input  wire logic                   ctrl_pin,
  input  wire logic                   other_fault,
  output logic                        out_enable,
  output logic                        ot_warning,
  output logic                        ut_warning,
  output logic                        ut_fault
);
  import tlfr_pkg::*;

  typedef struct packed {
    logic [15:0]    ot_warn_lim;
    logic [15:0]    ut_warn_lim;
    logic [15:0]    ut_fault_lim;
    logic [7:0]     action;
    logic [7:0]     time_unit;
    logic [7:0]     oper;
    logic [7:0]     status;
    logic [2:0]     req_sync;
    logic [1:0]     ctl_sync;
    logic           on_prev;
    tlfr_state_type fsm;
    logic [11:0]    pre;
    logic [7:0]     units;
    logic [2:0]     tries;
    logic           ack_tgl;
    logic [15:0]    rdata;
    logic           out_en;
  } tlfr_core_type;

  tlfr_core_type s_q;
  tlfr_core_type s_d;
  logic          req_tgl;
  tlfr_req_type  req_bus;

  logic                req_edge;
  logic                wr_stb;
  logic                cmd_on;
  logic                clr_evt;
  logic                tmr_start;
  logic                expire;
  logic [11:0]         pre_max;
  logic [7:0]          target;
  logic [1:0]          mode;
  logic [2:0]          retries;
  logic [2:0]          tries_nx;
  logic [7:0]          st_set;
  logic [7:0]          st_clr;
  logic signed [31:0]  t_val;
  logic                otw_now;
  logic                utw_now;
  logic                utf_now;

  // ****************************************************************
  // link-side handshake end
  // ****************************************************************
  tlfr_link_port u_link (
    .link_clk   (link_clk),
    .arst_n     (arst_n),
    .link_req   (link_req),
    .link_bus   (link_bus),
    .link_busy  (link_busy),
    .link_done  (link_done),
    .link_rdata (link_rdata),
    .req_tgl    (req_tgl),
    .req_bus    (req_bus),
    .ack_tgl    (s_q.ack_tgl),
    .core_rdata (s_q.rdata)
  );

  // ****************************************************************
  // linear format to signed value, four fraction bits
  // ****************************************************************
  function automatic logic signed [31:0] tlfr_lin(input logic [15:0] v);
    logic signed [5:0]  e;
    logic signed [5:0]  ne;
    logic signed [31:0] x;
    e = $signed({v[15], v[15:11]}) + 6'sd4;
    ne = 6'sd0 - e;
    x = $signed({{21{v[10]}}, v[10:0]});
    if (e >= 6'sd0) begin
      tlfr_lin = x <<< e[4:0];
    end else begin
      tlfr_lin = x >>> ne[4:0];
    end
  endfunction : tlfr_lin

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.req_sync = {s_q.req_sync[1:0], req_tgl};
    s_d.ctl_sync = {s_q.ctl_sync[0], ctrl_pin};
    req_edge = s_q.req_sync[1] ^ s_q.req_sync[2];
    wr_stb = req_edge && req_bus.write;
    mode = s_q.action[TLFR_MODE_HI:TLFR_MODE_LO];
    retries = s_q.action[TLFR_RETRY_HI:TLFR_RETRY_LO];
    tries_nx = s_q.tries + 3'h1;

    // threshold compare against live temperature
    t_val = tlfr_lin(temp_linear);
    otw_now = t_val > tlfr_lin(s_q.ot_warn_lim);
    utw_now = t_val < tlfr_lin(s_q.ut_warn_lim);
    utf_now = t_val < tlfr_lin(s_q.ut_fault_lim);

    // register access; unmapped codes read zero, writes ignored
    st_set = '0;
    st_set[TLFR_ST_OTW] = otw_now;
    st_set[TLFR_ST_UTW] = utw_now;
    st_set[TLFR_ST_UTF] = utf_now;
    st_clr = '0;
    clr_evt = 1'b0;
    if (req_edge) begin
      s_d.ack_tgl = ~s_q.ack_tgl;
      s_d.rdata = '0;
      unique case (req_bus.code)
        TLFR_CODE_OT_WARN: begin
          s_d.rdata = s_q.ot_warn_lim;
          if (wr_stb) begin
            s_d.ot_warn_lim = req_bus.wdata;
          end
        end
        TLFR_CODE_UT_WARN: begin
          s_d.rdata = s_q.ut_warn_lim;
          if (wr_stb) begin
            s_d.ut_warn_lim = req_bus.wdata;
          end
        end
        TLFR_CODE_UT_FAULT: begin
          s_d.rdata = s_q.ut_fault_lim;
          if (wr_stb) begin
            s_d.ut_fault_lim = req_bus.wdata;
          end
        end
        TLFR_CODE_UT_ACTION: begin
          s_d.rdata = {8'h00, s_q.action};
          if (wr_stb) begin
            s_d.action = req_bus.wdata[7:0];
          end
        end
        TLFR_CODE_TIME_UNIT: begin
          s_d.rdata = {8'h00, s_q.time_unit};
          if (wr_stb) begin
            s_d.time_unit = req_bus.wdata[7:0];
          end
        end
        TLFR_CODE_OPER: begin
          s_d.rdata = {8'h00, s_q.oper};
          if (wr_stb) begin
            s_d.oper = req_bus.wdata[7:0];
          end
        end
        TLFR_CODE_STATUS: begin
          s_d.rdata = {8'h00, s_q.status};
          if (wr_stb) begin
            st_clr = req_bus.wdata[7:0];
            clr_evt = req_bus.wdata[TLFR_ST_UTF];
          end
        end
        TLFR_CODE_CLR_FAULTS: begin
          if (wr_stb) begin
            st_clr = 8'hFF;
            clr_evt = 1'b1;
          end
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end
    // a condition present in the clearing cycle keeps its flag
    s_d.status = (s_q.status & ~st_clr) | st_set;

    // output command from pin and operation bit
    cmd_on = s_q.ctl_sync[1] & s_q.oper[TLFR_OPER_ON];
    s_d.on_prev = cmd_on;
    if (cmd_on && !s_q.on_prev) begin
      clr_evt = 1'b1;
    end

    // delay timer: 2^code units of (unit+1) base ticks each
    pre_max = 12'(({4'h0, s_q.time_unit} + 12'h001) * TLFR_TICK_CYC
                  - 12'h001);
    target = 8'h01 << s_q.action[TLFR_DLY_HI:TLFR_DLY_LO];
    expire = (s_q.pre == pre_max) && (s_q.units == target - 8'h01);
    tmr_start = 1'b0;

    // fault response
    if (!cmd_on) begin
      s_d.fsm = TLFR_RUN;
      s_d.tries = '0;
    end else if (clr_evt && s_q.fsm != TLFR_RUN) begin
      s_d.fsm = TLFR_RUN;
      s_d.tries = '0;
    end else begin
      unique case (s_q.fsm)
        TLFR_RUN: begin
          if (utf_now) begin
            unique case (mode)
              TLFR_MODE_IGNORE: begin
                s_d.fsm = TLFR_RUN;
              end
              TLFR_MODE_DELAY: begin
                s_d.fsm = TLFR_DELAY;
                tmr_start = 1'b1;
              end
              TLFR_MODE_RETRY: begin
                tmr_start = 1'b1;
                s_d.tries = '0;
                if (retries == TLFR_RETRY_NONE) begin
                  s_d.fsm = TLFR_LATCHED;
                end else begin
                  s_d.fsm = TLFR_OFF_WAIT;
                end
              end
              TLFR_MODE_LATCH: begin
                s_d.fsm = TLFR_LATCHED;
              end
            endcase
          end
        end
        TLFR_DELAY: begin
          if (!utf_now) begin
            s_d.fsm = TLFR_RUN;
          end else if (expire) begin
            tmr_start = 1'b1;
            s_d.tries = '0;
            if (retries == TLFR_RETRY_NONE) begin
              s_d.fsm = TLFR_LATCHED;
            end else begin
              s_d.fsm = TLFR_OFF_WAIT;
            end
          end
        end
        TLFR_OFF_WAIT: begin
          if (other_fault) begin
            s_d.fsm = TLFR_LATCHED;
          end else if (expire) begin
            // a restart attempt starts here, one delay after the last
            if (!utf_now) begin
              s_d.fsm = TLFR_RUN;
            end else if (retries != TLFR_RETRY_FOREVER &&
                         tries_nx == retries) begin
              s_d.fsm = TLFR_LATCHED;
            end else begin
              s_d.tries = tries_nx;
              tmr_start = 1'b1;
            end
          end
        end
        TLFR_LATCHED: begin
          s_d.fsm = TLFR_LATCHED;
        end
      endcase
    end

    if (tmr_start ||
        !(s_q.fsm == TLFR_DELAY || s_q.fsm == TLFR_OFF_WAIT)) begin
      s_d.pre = '0;
      s_d.units = '0;
    end else if (s_q.pre == pre_max) begin
      s_d.pre = '0;
      s_d.units = s_q.units + 8'h01;
    end else begin
      s_d.pre = s_q.pre + 12'h001;
    end
    s_d.out_en = cmd_on &&
                 (s_d.fsm == TLFR_RUN || s_d.fsm == TLFR_DELAY);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.ot_warn_lim <= TLFR_RST_OT_WARN;
      s_q.ut_warn_lim <= TLFR_RST_UT_WARN;
      s_q.ut_fault_lim <= TLFR_RST_UT_FAULT;
      s_q.action <= TLFR_RST_UT_ACTION;
      s_q.time_unit <= TLFR_RST_TIME_UNIT;
      s_q.oper <= TLFR_RST_OPER;
      s_q.fsm <= TLFR_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  assign out_enable = s_q.out_en;
  assign ot_warning = s_q.status[TLFR_ST_OTW];
  assign ut_warning = s_q.status[TLFR_ST_UTW];
  assign ut_fault   = s_q.status[TLFR_ST_UTF];

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_fault_hit(logic [1:0] m);
    s_q.fsm == TLFR_RUN && utf_now && mode == m && cmd_on && !clr_evt;
  endsequence

  property p_otw_flag;
    @(posedge clk) disable iff (!arst_n)
    otw_now |=> ot_warning;
  endproperty
  a_otw_flag: assert property (p_otw_flag)
    else $error("over-temperature warning flag not set");

  property p_utw_flag;
    @(posedge clk) disable iff (!arst_n)
    utw_now |=> ut_warning;
  endproperty
  a_utw_flag: assert property (p_utw_flag)
    else $error("under-temperature warning flag not set");

  property p_utf_flag;
    @(posedge clk) disable iff (!arst_n)
    (utf_now ##1 1'b1) |-> ut_fault;
  endproperty
  a_utf_flag: assert property (p_utf_flag)
    else $error("under-temperature fault flag not set");

  property p_ignore;
    @(posedge clk) disable iff (!arst_n)
    s_fault_hit(TLFR_MODE_IGNORE) |=> out_enable && s_q.fsm == TLFR_RUN;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("ignored fault interrupted the output");

  property p_delay_on;
    @(posedge clk) disable iff (!arst_n)
    s_fault_hit(TLFR_MODE_DELAY) |=> out_enable && s_q.fsm == TLFR_DELAY
      && s_q.pre == 12'h000 && s_q.units == 8'h00;
  endproperty
  a_delay_on: assert property (p_delay_on)
    else $error("delay mode did not keep running");

  property p_retry_off;
    @(posedge clk) disable iff (!arst_n)
    s_fault_hit(TLFR_MODE_RETRY) |=> !out_enable &&
      s_q.fsm == ($past(retries) == TLFR_RETRY_NONE ? TLFR_LATCHED
                                                    : TLFR_OFF_WAIT);
  endproperty
  a_retry_off: assert property (p_retry_off)
    else $error("retry mode did not disable at once");

  property p_latch_hold;
    @(posedge clk) disable iff (!arst_n)
    s_q.fsm == TLFR_LATCHED && cmd_on && !clr_evt |=>
      !out_enable && s_q.fsm == TLFR_LATCHED;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched fault released without a clear");

  property p_latch_clear;
    @(posedge clk) disable iff (!arst_n)
    s_q.fsm == TLFR_LATCHED && cmd_on && clr_evt |=>
      s_q.fsm == TLFR_RUN ##1 1'b1;
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("clear did not release the latched fault");

  property p_last_try;
    @(posedge clk) disable iff (!arst_n)
    s_q.fsm == TLFR_OFF_WAIT && expire && utf_now && cmd_on && !clr_evt
      && !other_fault && retries != TLFR_RETRY_FOREVER
      && tries_nx == retries |=> s_q.fsm == TLFR_LATCHED;
  endproperty
  a_last_try: assert property (p_last_try)
    else $error("retries exhausted but output not latched off");

  property p_forever;
    @(posedge clk) disable iff (!arst_n)
    s_q.fsm == TLFR_OFF_WAIT && expire && utf_now && cmd_on && !clr_evt
      && !other_fault && retries == TLFR_RETRY_FOREVER
      |=> s_q.fsm == TLFR_OFF_WAIT && s_q.units == 8'h00;
  endproperty
  a_forever: assert property (p_forever)
    else $error("continuous retry stopped");

  property p_units_bound;
    @(posedge clk) disable iff (!arst_n)
    s_q.fsm == TLFR_OFF_WAIT |-> s_q.units < target && s_q.pre <= pre_max;
  endproperty
  a_units_bound: assert property (p_units_bound)
    else $error("delay counter ran past its target");

endmodule : tlfr_core

`default_nettype wire

// ### verilog/tlfr_link_port.sv
// link-clock end of the register access handshake
`timescale 1ns/10ps
`default_nettype none

module tlfr_link_port (
  input  wire logic                  link_clk,
  input  wire logic                  arst_n,
  input  wire logic                  link_req,
  input  wire tlfr_pkg::tlfr_req_type link_bus,
  output logic                       link_busy,
  output logic                       link_done,
  output logic [15:0]                link_rdata,
  output logic                       req_tgl,
  output tlfr_pkg::tlfr_req_type     req_bus,
  input  wire logic                  ack_tgl,
  input  wire logic [15:0]           core_rdata
);
  import tlfr_pkg::*;

  typedef struct packed {
    logic         req_tgl;
    tlfr_req_type bus;
    logic         busy;
    logic         done;
    logic [2:0]   ack_sync;
    logic [15:0]  rdata;
  } tlfr_link_type;

  tlfr_link_type s_q;
  tlfr_link_type s_d;
  logic          ack_edge;

  // ****************************************************************
  // handshake
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.ack_sync = {s_q.ack_sync[1:0], ack_tgl};
    ack_edge = s_q.ack_sync[1] ^ s_q.ack_sync[2];
    if (ack_edge) begin
      // core holds its answer word stable until the next request
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
      s_d.rdata = core_rdata;
    end else if (link_req && !s_q.busy) begin
      s_d.bus = link_bus;
      s_d.req_tgl = ~s_q.req_tgl;
      s_d.busy = 1'b1;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign link_busy  = s_q.busy;
  assign link_done  = s_q.done;
  assign link_rdata = s_q.rdata;
  assign req_tgl    = s_q.req_tgl;
  assign req_bus    = s_q.bus;

endmodule : tlfr_link_port

`default_nettype wire

// ### verilog/tlfr_pkg.sv
// constants, codes and carrier types of the temperature limit block
package tlfr_pkg;

  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [7:0] TLFR_CODE_OPER       = 8'h01;
  localparam logic [7:0] TLFR_CODE_CLR_FAULTS = 8'h03;
  localparam logic [7:0] TLFR_CODE_OT_WARN    = 8'h51;
  localparam logic [7:0] TLFR_CODE_UT_WARN    = 8'h52;
  localparam logic [7:0] TLFR_CODE_UT_FAULT   = 8'h53;
  localparam logic [7:0] TLFR_CODE_UT_ACTION  = 8'h54;
  localparam logic [7:0] TLFR_CODE_STATUS     = 8'h7D;
  localparam logic [7:0] TLFR_CODE_TIME_UNIT  = 8'hD2;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int TLFR_MODE_HI   = 7;
  localparam int TLFR_MODE_LO   = 6;
  localparam int TLFR_RETRY_HI  = 5;
  localparam int TLFR_RETRY_LO  = 3;
  localparam int TLFR_DLY_HI    = 2;
  localparam int TLFR_DLY_LO    = 0;
  localparam int TLFR_OPER_ON   = 7;
  localparam int TLFR_ST_OTW    = 6;
  localparam int TLFR_ST_UTW    = 5;
  localparam int TLFR_ST_UTF    = 4;

  // ****************************************************************
  // field values
  // ****************************************************************
  localparam logic [1:0] TLFR_MODE_IGNORE  = 2'h0;
  localparam logic [1:0] TLFR_MODE_DELAY   = 2'h1;
  localparam logic [1:0] TLFR_MODE_RETRY   = 2'h2;
  localparam logic [1:0] TLFR_MODE_LATCH   = 2'h3;
  localparam logic [2:0] TLFR_RETRY_NONE   = 3'h0;
  localparam logic [2:0] TLFR_RETRY_FOREVER = 3'h7;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] TLFR_RST_OT_WARN   = 16'h7BFF;
  localparam logic [15:0] TLFR_RST_UT_WARN   = 16'hFC00;
  localparam logic [15:0] TLFR_RST_UT_FAULT  = 16'hFC00;
  localparam logic [7:0]  TLFR_RST_UT_ACTION = 8'h00;
  localparam logic [7:0]  TLFR_RST_TIME_UNIT = 8'h00;
  localparam logic [7:0]  TLFR_RST_OPER      = 8'h80;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          TLFR_CLK_NS    = 100;
  localparam int          TLFR_TICK_NS   = 1000;
  localparam logic [11:0] TLFR_TICK_CYC  = 12'(TLFR_TICK_NS / TLFR_CLK_NS);

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    TLFR_RUN      = 2'b00,
    TLFR_DELAY    = 2'b01,
    TLFR_OFF_WAIT = 2'b10,
    TLFR_LATCHED  = 2'b11
  } tlfr_state_type;

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } tlfr_req_type;

endpackage : tlfr_pkg
